/* hw/snv_core.sv */
// Serial nvSRAM command decoder, status register and write-data FIFO
`timescale 1ns/1ps

module snv_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : snv_fifo

// Overview of operation
// - Power-up clears write latch, keeps saved bits
// - Power-up restore blocks access, busy shown
// - After power-up follow chip select, never held
// - Below threshold ignore commands, finish write
// - Power-down save only if written since restore
// - Standby after delay once save/restore done
// - Opcode on select fall, MSB first
// - Decode status read and status write
// - Latch set command sets write latch
// - Latch clear command clears write latch
// - Decode array read and array write
// - Decode software save and restore
// - Decode autosave enable and disable
// - Decode sleep, serial write, serial read
// - Decode identification read; reserved is invalid
// - Status bit layout fixed
// - Busy bit read-only, high during save/restore
// - Status write changes only protect, pin-protect enable and serial lock bits
// - Bits 4 and 5 read zero
// - Serial lock is set-once; blocks serial writes
// - Write latch reflects write enable
// - Pin-protect enable gates protect pin
// - Protect level makes array ranges read-only
// - Latch cleared after each write-type command that is not ignored
// - Unknown opcode ignored until next select
// - Protect pin low with enable rejects status write
module snv_core
   import snv_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic power_good,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic wp_n,
   output logic hw_save_busy_pin,
   output logic standby,
   output logic sleep_mode,
   output logic autosave_enable,
   output logic mem_wr_valid,
   input wire logic mem_wr_ready,
   output logic [12:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   output logic [12:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data
);
   logic [2:0] sclk_s, cs_s, mosi_s;
   logic [1:0] wp_s, pg_s;
   logic sclk_rise, sclk_fall, cs_fall, cs_rise, selected;
   snv_state_t state;
   logic [7:0] shift, opcode, out_byte, tx;
   logic [2:0] bit_cnt;
   logic [1:0] addr_cnt;
   logic [3:0] byte_cnt;
   logic [12:0] addr;
   logic write_latch, prot_lo, prot_hi, serial_lock, pin_protect_enable;
   logic saved_lo, saved_hi, saved_pin;
   logic [TIMER_W-1:0] busy_cnt, standby_cnt, finish_cnt;
   logic busy, dirty, powered, shutting, finish_pending;
   logic [7:0] serial_no [SN_BYTES];
   logic byte_done, fifo_in_ready, fifo_in_valid;
   logic [20:0] fifo_out;
   logic [1:0] level;
   logic protected_addr, status_locked;
   logic [7:0] status_value;

   // Two flops before use; the third stage only feeds edge detection
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         sclk_s <= '0;
         cs_s <= 3'h7;
         mosi_s <= '0;
         wp_s <= 2'h3;
         pg_s <= '0;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], sclk};
         cs_s <= {cs_s[1:0], cs_n};
         mosi_s <= {mosi_s[1:0], mosi};
         wp_s <= {wp_s[0], wp_n};
         pg_s <= {pg_s[0], power_good};
      end
   end

   // Mode 0/3 both sample rising and shift out falling, so mode needs no state
   assign sclk_rise = sclk_s[1] && !sclk_s[2];
   assign sclk_fall = !sclk_s[1] && sclk_s[2];
   assign cs_fall = !cs_s[1] && cs_s[2];
   assign cs_rise = cs_s[1] && !cs_s[2];
   assign selected = !cs_s[1];
   assign byte_done = sclk_rise && bit_cnt == BIT_LAST;

   assign level = {prot_hi, prot_lo};
   assign protected_addr = (level == PROT_NONE) ? 1'b0 :
                           (level == PROT_QUARTER) ? (addr >= PROT_L1_BASE) :
                           (level == PROT_HALF) ? (addr >= PROT_L2_BASE) : 1'b1;
   assign status_locked = !wp_s[1] && pin_protect_enable;
   assign status_value = {pin_protect_enable, serial_lock, 2'h0, prot_hi, prot_lo,
                          write_latch, busy};

   // Instruction sequencer
   always_ff @(posedge mclk)
   begin
      if (srst || !selected)
      begin
         state <= SNV_IDLE;
         bit_cnt <= '0;
         addr_cnt <= '0;
         byte_cnt <= '0;
         shift <= '0;
         opcode <= '0;
         addr <= '0;
      end
      else if (cs_fall)
      begin
         state <= (powered && !shutting) ? SNV_OPCODE : SNV_IGNORE;
         bit_cnt <= '0;
      end
      else if (sclk_rise)
      begin
         shift <= {shift[6:0], mosi_s[1]};
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_done)
         begin
            case (state)
               SNV_OPCODE:
               begin
                  opcode <= {shift[6:0], mosi_s[1]};
                  case ({shift[6:0], mosi_s[1]})
                     STATUS_READ_CMD, IDENT_READ_CMD: state <= SNV_DATA_OUT;
                     SERIAL_NUMBER_READ_CMD: state <= SNV_DATA_OUT;
                     STATUS_WRITE_CMD, SERIAL_NUMBER_WRITE_CMD:
                        state <= write_latch ? SNV_DATA_IN : SNV_IGNORE;
                     ARRAY_READ_CMD: state <= busy ? SNV_IGNORE : SNV_ADDR;
                     ARRAY_WRITE_CMD:
                        state <= (write_latch && !busy) ? SNV_ADDR : SNV_IGNORE;
                     WRITE_LATCH_SET_CMD, WRITE_LATCH_CLEAR_CMD, SLEEP_CMD: state <= SNV_DONE;
                     NV_SAVE_CMD, NV_RESTORE_CMD, AUTOSAVE_ON_CMD, AUTOSAVE_OFF_CMD:
                        state <= SNV_DONE;
                     default: state <= SNV_IGNORE;
                  endcase
               end
               SNV_ADDR:
               begin
                  addr <= {addr[4:0], shift[6:0], mosi_s[1]};
                  addr_cnt <= addr_cnt + 2'h1;
                  if (addr_cnt + 2'h1 == ADDR_BYTES)
                  begin
                     state <= (opcode == ARRAY_READ_CMD) ? SNV_DATA_OUT : SNV_DATA_IN;
                  end
               end
               SNV_DATA_IN:
               begin
                  byte_cnt <= byte_cnt + 4'h1;
                  if (opcode == ARRAY_WRITE_CMD)
                  begin
                     addr <= addr + 13'h1;
                  end
                  if (opcode == STATUS_WRITE_CMD)
                  begin
                     state <= SNV_DONE;
                  end
               end
               SNV_DATA_OUT:
               begin
                  byte_cnt <= byte_cnt + 4'h1;
                  addr <= addr + 13'h1;
               end
               default: state <= state;
            endcase
         end
      end
   end

   assign mem_rd_addr = addr;

   always_comb
   begin
      tx = 8'h0;
      case (opcode)
         STATUS_READ_CMD: tx = status_value;
         SERIAL_NUMBER_READ_CMD: tx = serial_no[byte_cnt[2:0]];
         IDENT_READ_CMD: tx = ID_PATTERN ^ {4'h0, byte_cnt};
         ARRAY_READ_CMD: tx = mem_rd_data;
         default: tx = 8'h0;
      endcase
   end

   // Output shifts on falling clock; tri-stated unless a read is in progress
   always_ff @(posedge mclk)
   begin
      if (srst || state != SNV_DATA_OUT)
      begin
         out_byte <= '0;
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end
      else if (sclk_fall)
      begin
         miso_oe <= 1'b1;
         if (bit_cnt == 3'h0)
         begin
            miso <= tx[7];
            out_byte <= {tx[6:0], 1'b0};
         end
         else
         begin
            miso <= out_byte[7];
            out_byte <= {out_byte[6:0], 1'b0};
         end
      end
   end

   // Write data queued so the array side can stall for up to eight words; a byte arriving while full is dropped
   assign fifo_in_valid = state == SNV_DATA_IN && byte_done && opcode == ARRAY_WRITE_CMD &&
                          !protected_addr && !shutting;

   snv_fifo #(.WIDTH(21), .DEPTH(8)) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({addr, shift[6:0], mosi_s[1]}),
      .out_valid(mem_wr_valid),
      .out_ready(mem_wr_ready),
      .out_data(fifo_out)
   );
   assign mem_wr_addr = fifo_out[20:8];
   assign mem_wr_data = fifo_out[7:0];

   // Status register; srst stands for power-up
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         write_latch <= 1'b0;
         prot_lo <= 1'b0;
         prot_hi <= 1'b0;
         pin_protect_enable <= 1'b0;
         serial_lock <= 1'b0;
      end
      else if (!powered)
      begin
         write_latch <= 1'b0;
         prot_lo <= saved_lo;
         prot_hi <= saved_hi;
         pin_protect_enable <= saved_pin;
      end
      else if (cs_rise)
      begin
         case (opcode)
            WRITE_LATCH_SET_CMD: write_latch <= state == SNV_DONE;
            WRITE_LATCH_CLEAR_CMD: write_latch <= 1'b0;
            STATUS_WRITE_CMD, ARRAY_WRITE_CMD, SERIAL_NUMBER_WRITE_CMD, NV_SAVE_CMD,
            NV_RESTORE_CMD, AUTOSAVE_ON_CMD, AUTOSAVE_OFF_CMD:
               if (state != SNV_IGNORE) write_latch <= 1'b0;
            default: write_latch <= write_latch;
         endcase
      end
      else if (state == SNV_DATA_IN && byte_done && opcode == STATUS_WRITE_CMD &&
               !status_locked)
      begin
         prot_lo <= shift[PROTECT_SEL_LO_BIT - 1];
         prot_hi <= shift[PROTECT_SEL_HI_BIT - 1];
         pin_protect_enable <= shift[PIN_PROTECT_ENABLE_BIT - 1];
         serial_lock <= serial_lock | shift[SERIAL_LOCK_BIT - 1];
      end
   end

   // Serial number bytes, refused once locked
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < SN_BYTES; i++) serial_no[i] <= 8'h0;
      end
      else if (state == SNV_DATA_IN && byte_done && opcode == SERIAL_NUMBER_WRITE_CMD &&
               !serial_lock && byte_cnt < SN_BYTES)
      begin
         serial_no[byte_cnt[2:0]] <= {shift[6:0], mosi_s[1]};
      end
   end

   // Busy timer for restore at power-up, software save/restore and autosave
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         busy_cnt <= TIMER_W'(POWERUP_RESTORE_CYC);
         powered <= 1'b0;
         shutting <= 1'b0;
         finish_pending <= 1'b0;
         finish_cnt <= '0;
         dirty <= 1'b0;
         autosave_enable <= 1'b1;
         saved_lo <= 1'b0;
         saved_hi <= 1'b0;
         saved_pin <= 1'b0;
      end
      else
      begin
         if (busy_cnt != '0)
         begin
            busy_cnt <= busy_cnt - 1'b1;
         end
         else
         begin
            powered <= 1'b1;
         end
         if (fifo_in_valid)
         begin
            dirty <= 1'b1;
         end
         if (cs_rise && state == SNV_DONE && !busy)
         begin
            case (opcode)
               NV_SAVE_CMD:
               begin
                  busy_cnt <= TIMER_W'(SAVE_CYC);
                  {saved_pin, saved_hi, saved_lo} <= {pin_protect_enable, prot_hi, prot_lo};
               end
               NV_RESTORE_CMD:
               begin
                  busy_cnt <= TIMER_W'(RESTORE_CYC);
                  dirty <= 1'b0;
               end
               AUTOSAVE_ON_CMD: autosave_enable <= 1'b1;
               AUTOSAVE_OFF_CMD: autosave_enable <= 1'b0;
               default: autosave_enable <= autosave_enable;
            endcase
         end
         if (powered && !pg_s[1] && !shutting)
         begin
            shutting <= 1'b1;
            finish_pending <= 1'b1;
            finish_cnt <= TIMER_W'(WRITE_FINISH_CYC);
         end
         if (finish_pending)
         begin
            if (finish_cnt != '0)
            begin
               finish_cnt <= finish_cnt - 1'b1;
            end
            else
            begin
               finish_pending <= 1'b0;
               if (autosave_enable && dirty)
               begin
                  busy_cnt <= TIMER_W'(SAVE_CYC);
                  {saved_pin, saved_hi, saved_lo} <= {pin_protect_enable, prot_hi, prot_lo};
               end
            end
         end
      end
   end

   assign busy = busy_cnt != '0;
   assign hw_save_busy_pin = busy;

   // Standby timer held off while a save or restore runs
   always_ff @(posedge mclk)
   begin
      if (srst || selected || busy)
      begin
         standby_cnt <= TIMER_W'(STANDBY_ENTRY_CYC);
         standby <= 1'b0;
      end
      else if (standby_cnt != '0)
      begin
         standby_cnt <= standby_cnt - 1'b1;
      end
      else
      begin
         standby <= 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst || cs_fall)
      begin
         sleep_mode <= 1'b0;
      end
      else if (cs_rise && state == SNV_DONE && opcode == SLEEP_CMD)
      begin
         sleep_mode <= 1'b1;
      end
   end
endmodule : snv_core

/* hw/snv_pkg.sv */
// Shared constants for the serial nvSRAM command and status front end
package snv_pkg;
   localparam int MCLK_HZ = 40000000;
   localparam int POWERUP_RESTORE_TIME_US = 20;
   localparam int WRITE_FINISH_WINDOW_US = 25;
   localparam int STANDBY_ENTRY_TIME_US = 100;
   localparam int SAVE_TIME_US = 8000;
   localparam int RESTORE_TIME_US = 200;
   localparam int US_DIV = 1000000;
   localparam int POWERUP_RESTORE_CYC = POWERUP_RESTORE_TIME_US * (MCLK_HZ / US_DIV);
   localparam int WRITE_FINISH_CYC = WRITE_FINISH_WINDOW_US * (MCLK_HZ / US_DIV);
   localparam int STANDBY_ENTRY_CYC = STANDBY_ENTRY_TIME_US * (MCLK_HZ / US_DIV);
   localparam int SAVE_CYC = SAVE_TIME_US * (MCLK_HZ / US_DIV);
   localparam int RESTORE_CYC = RESTORE_TIME_US * (MCLK_HZ / US_DIV);
   localparam int TIMER_W = 20;

   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
   localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
   localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
   localparam logic [7:0] NV_SAVE_CMD = 8'h3c;
   localparam logic [7:0] NV_RESTORE_CMD = 8'h60;
   localparam logic [7:0] AUTOSAVE_ON_CMD = 8'h59;
   localparam logic [7:0] AUTOSAVE_OFF_CMD = 8'h19;
   localparam logic [7:0] SLEEP_CMD = 8'hb9;
   localparam logic [7:0] SERIAL_NUMBER_WRITE_CMD = 8'hc2;
   localparam logic [7:0] SERIAL_NUMBER_READ_CMD = 8'hc3;
   localparam logic [7:0] IDENT_READ_CMD = 8'h9f;
   localparam logic [7:0] RESERVED_CMD = 8'h1e;

   localparam int BUSY_BIT = 0;
   localparam int WRITE_LATCH_BIT = 1;
   localparam int PROTECT_SEL_LO_BIT = 2;
   localparam int PROTECT_SEL_HI_BIT = 3;
   localparam int SERIAL_LOCK_BIT = 6;
   localparam int PIN_PROTECT_ENABLE_BIT = 7;

   localparam logic [12:0] PROT_L1_BASE = 13'h1800;
   localparam logic [12:0] PROT_L2_BASE = 13'h1000;
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_QUARTER = 2'h1;
   localparam logic [1:0] PROT_HALF = 2'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] SN_BYTES = 4'h8;
   localparam logic [1:0] ADDR_BYTES = 2'h2;
   localparam logic [7:0] ID_PATTERN = 8'ha5; // Arbitrary identification value
   localparam logic [3:0] ID_BYTES = 4'h4;

   typedef enum logic [6:0] {
      SNV_IDLE = 7'h01,
      SNV_OPCODE = 7'h02,
      SNV_ADDR = 7'h04,
      SNV_DATA_IN = 7'h08,
      SNV_DATA_OUT = 7'h10,
      SNV_IGNORE = 7'h20,
      SNV_DONE = 7'h40
   } snv_state_t;
endpackage : snv_pkg

/* tb/snv_core_asserts.sv */
// Port-level checks on the nvSRAM command front end
`timescale 1ns/1ps
module snv_core_asserts
   import snv_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic power_good,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic wp_n,
   input wire logic hw_save_busy_pin,
   input wire logic standby,
   input wire logic sleep_mode,
   input wire logic autosave_enable,
   input wire logic mem_wr_valid,
   input wire logic mem_wr_ready,
   input wire logic [12:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   input wire logic [12:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data
);
   localparam int PU_MAX = 900;
   localparam logic [12:0] STBY_MIN = 13'(STANDBY_ENTRY_CYC - 8);
   logic [12:0] cs_hi_cnt;

   // Saturates so a long idle stretch never wraps back under the minimum
   always_ff @(posedge mclk)
   begin
      if (srst || !cs_n)
         cs_hi_cnt <= 13'h0;
      else if (cs_hi_cnt != 13'h1fff)
         cs_hi_cnt <= cs_hi_cnt + 13'h1;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence s_release;
      $fell(srst);
   endsequence
   sequence s_restore_done;
      hw_save_busy_pin [*8] ##[1:PU_MAX] !hw_save_busy_pin;
   endsequence

   chk_busy_powerup: assert property (s_release |-> s_restore_done)
      else $error("busy pin wrong after power-up");
   chk_autosave_reset: assert property (s_release |-> autosave_enable)
      else $error("autosave not on after power-up");
   chk_oe_idle: assert property (cs_n [*8] |-> !miso_oe)
      else $error("output driven while deselected");
   chk_oe_selected: assert property ($rose(miso_oe) |-> !cs_n)
      else $error("output enabled without select");
   chk_stby_active: assert property (!cs_n [*8] |-> !standby)
      else $error("standby while selected");
   chk_stby_delay: assert property ($rose(standby) |-> cs_hi_cnt >= STBY_MIN)
      else $error("standby entered too early");
   chk_stby_idle: assert property ($rose(standby) |-> !hw_save_busy_pin)
      else $error("standby during save or restore");
   chk_sleep_clear: assert property (!cs_n [*8] |-> !sleep_mode)
      else $error("sleep kept while selected");
   chk_sleep_set: assert property ($rose(sleep_mode) |-> cs_n)
      else $error("sleep entered while selected");
   chk_wr_stall: assert property (mem_wr_valid && !mem_wr_ready |=>
      mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
      else $error("write word changed while stalled");
endmodule : snv_core_asserts

bind snv_core snv_core_asserts u_chk (.mclk(mclk), .srst(srst), .power_good(power_good),
   .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n),
   .hw_save_busy_pin(hw_save_busy_pin), .standby(standby), .sleep_mode(sleep_mode),
   .autosave_enable(autosave_enable), .mem_wr_valid(mem_wr_valid),
   .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
   .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));

/* tb/snv_spi_master.sv */
// Mode 0 serial bus master model facing the front end
`timescale 1ns/1ps
module snv_spi_master (
   input wire logic mclk,
   input wire logic miso,
   input wire logic miso_oe,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   logic miso_line;
   logic flip;

   // Released line wanders each cycle so a stale bit never passes for data
   assign miso_line = miso_oe ? miso : flip;

   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      flip = 1'b0;
   end

   always @(posedge mclk)
      flip <= ~flip;

   task open_frame();
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : open_frame

   // Clock stands low outside frames; 8 mclk per serial bit gives 200 ns
   task xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi <= tx[i];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         rx[i] = miso_line;
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
   endtask : xbyte

   task close_frame();
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (8) @(posedge mclk);
   endtask : close_frame
endmodule : snv_spi_master

/* tb/snv_core_test.sv */
// Self-checking bench for the nvSRAM command front end
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module snv_core_test
   import snv_pkg::*;
   ;
   logic mclk, srst, power_good, wp_n, mem_wr_ready, sclk, cs_n, mosi, miso, miso_oe;
   logic hw_save_busy_pin, standby, sleep_mode, autosave_enable, mem_wr_valid, oe_seen;
   logic [12:0] mem_wr_addr, mem_rd_addr;
   logic [7:0] mem_wr_data, mem_rd_data, r, s;
   logic [12:0] wa [$];
   logic [7:0] wd [$];
   int n_errors, checked, cyc;

   snv_core u_dut (.mclk(mclk), .srst(srst), .power_good(power_good), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n),
      .hw_save_busy_pin(hw_save_busy_pin), .standby(standby), .sleep_mode(sleep_mode),
      .autosave_enable(autosave_enable), .mem_wr_valid(mem_wr_valid),
      .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
   snv_spi_master u_mst (.mclk(mclk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Array model answers one cycle after the address moves; also logs writes
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      mem_rd_data <= mem_rd_addr[7:0] ^ 8'h5a;
      if (miso_oe)
         oe_seen <= 1'b1;
      if (mem_wr_valid && mem_wr_ready)
      begin
         wa.push_back(mem_wr_addr);
         wd.push_back(mem_wr_data);
      end
      if (cyc == 60000)
      begin
         n_errors++;
         summarize();
      end
   end

   task summarize();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   task cmd(input logic [7:0] op);
      u_mst.open_frame();
      u_mst.xbyte(op, r);
      u_mst.close_frame();
   endtask : cmd

   task rd_status();
      u_mst.open_frame();
      u_mst.xbyte(STATUS_READ_CMD, r);
      u_mst.xbyte(8'h00, s);
      u_mst.close_frame();
   endtask : rd_status

   task wr_status(input logic [7:0] v, input logic latch);
      if (latch)
         cmd(WRITE_LATCH_SET_CMD);
      u_mst.open_frame();
      u_mst.xbyte(STATUS_WRITE_CMD, r);
      u_mst.xbyte(v, r);
      u_mst.close_frame();
      rd_status();
   endtask : wr_status

   task wait_idle(output int n);
      n = 0;
      while (hw_save_busy_pin !== 1'b0 && n < 10000)
      begin
         @(posedge mclk);
         n++;
      end
   endtask : wait_idle

   task sn_rw(input logic [7:0] v);
      cmd(WRITE_LATCH_SET_CMD);
      u_mst.open_frame();
      u_mst.xbyte(SERIAL_NUMBER_WRITE_CMD, r);
      u_mst.xbyte(v, r);
      u_mst.close_frame();
      u_mst.open_frame();
      u_mst.xbyte(SERIAL_NUMBER_READ_CMD, r);
      u_mst.xbyte(8'h00, r);
      u_mst.close_frame();
   endtask : sn_rw

   task t_powerup();
      int n;
      @(posedge mclk);
      `CHK(hw_save_busy_pin, 1'b1)
      wait_idle(n);
      `CHK(n > POWERUP_RESTORE_CYC - 20 && n < POWERUP_RESTORE_CYC + 20, 1'b1)
      rd_status();
      `CHK(s & 8'h33, 8'h00)
      sn_rw(8'h3c);
      `CHK(r, 8'h3c)
   endtask : t_powerup

   task t_status();
      cmd(WRITE_LATCH_SET_CMD);
      rd_status();
      `CHK(s[1], 1'b1)
      cmd(WRITE_LATCH_CLEAR_CMD);
      rd_status();
      `CHK(s[1], 1'b0)
      wr_status(8'hff, 1'b1);
      `CHK(s, 8'hcc)
      wr_status(8'h00, 1'b0);
      `CHK(s, 8'hcc)
      wr_status(8'h00, 1'b1);
      `CHK(s, 8'h40)
      sn_rw(8'h77);
      `CHK(r, 8'h3c)
   endtask : t_status

   task t_pin();
      wr_status(8'h80, 1'b1);
      wp_n <= 1'b0;
      wr_status(8'h0c, 1'b1);
      `CHK(s & 8'hfd, 8'hc0)
      wp_n <= 1'b1;
      wr_status(8'h04, 1'b1);
      wp_n <= 1'b0;
      wr_status(8'h08, 1'b1);
      `CHK(s, 8'h48)
      wp_n <= 1'b1;
   endtask : t_pin

   task t_awrite();
      cmd(WRITE_LATCH_SET_CMD);
      u_mst.open_frame();
      u_mst.xbyte(ARRAY_WRITE_CMD, r);
      u_mst.xbyte(8'hef, r);
      u_mst.xbyte(8'hfe, r);
      u_mst.xbyte(8'h11, r);
      u_mst.xbyte(8'h22, r);
      u_mst.xbyte(8'h33, r);
      u_mst.close_frame();
      repeat (20) @(posedge mclk);
      `CHK(wa.size(), 2)
      `CHK(wa[0], 13'h0ffe)
      `CHK(wd[1], 8'h22)
      wa.delete();
      wd.delete();
      rd_status();
      `CHK(s[1], 1'b0)
   endtask : t_awrite

   // Stalled drain: a refused burst first, then a full FIFO of eight words
   task t_fifo();
      wr_status(8'h00, 1'b1);
      mem_wr_ready <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1)
            cmd(WRITE_LATCH_SET_CMD);
         u_mst.open_frame();
         u_mst.xbyte(ARRAY_WRITE_CMD, r);
         u_mst.xbyte(8'h01, r);
         u_mst.xbyte(8'h00, r);
         for (int i = 0; i < 8; i++)
            u_mst.xbyte(8'(i + 1 + 16 * (1 - k)), r);
         u_mst.close_frame();
      end
      repeat (30) @(posedge mclk);
      `CHK(mem_wr_valid, 1'b1)
      mem_wr_ready <= 1'b1;
      repeat (20) @(posedge mclk);
      `CHK(wa.size(), 8)
      for (int i = 0; i < 8; i++)
      begin
         `CHK(wa[i], 13'(13'h100 + i))
         `CHK(wd[i], 8'(i + 1))
      end
      wa.delete();
      wd.delete();
   endtask : t_fifo

   task t_read();
      u_mst.open_frame();
      u_mst.xbyte(ARRAY_READ_CMD, r);
      u_mst.xbyte(8'h01, r);
      u_mst.xbyte(8'h23, r);
      u_mst.xbyte(8'h00, r);
      `CHK(r, 8'h79)
      u_mst.xbyte(8'h00, r);
      `CHK(r, 8'h7e)
      u_mst.close_frame();
      oe_seen <= 1'b0;
      u_mst.open_frame();
      u_mst.xbyte(RESERVED_CMD, r);
      u_mst.xbyte(8'h00, r);
      u_mst.xbyte(8'h00, r);
      u_mst.close_frame();
      `CHK(oe_seen, 1'b0)
   endtask : t_read

   task t_restore();
      int n;
      cmd(WRITE_LATCH_SET_CMD);
      cmd(NV_RESTORE_CMD);
      `CHK(hw_save_busy_pin, 1'b1)
      rd_status();
      `CHK(s[0], 1'b1)
      wait_idle(n);
      `CHK(n < RESTORE_CYC, 1'b1)
      rd_status();
      `CHK(s[1:0], 2'b00)
   endtask : t_restore

   task t_modes();
      cmd(WRITE_LATCH_SET_CMD);
      cmd(AUTOSAVE_OFF_CMD);
      `CHK(autosave_enable, 1'b0)
      cmd(WRITE_LATCH_SET_CMD);
      cmd(AUTOSAVE_ON_CMD);
      `CHK(autosave_enable, 1'b1)
      u_mst.open_frame();
      u_mst.xbyte(IDENT_READ_CMD, r);
      u_mst.xbyte(8'h00, r);
      `CHK(r, ID_PATTERN)
      u_mst.xbyte(8'h00, r);
      `CHK(r, ID_PATTERN ^ 8'h01)
      u_mst.close_frame();
      cmd(SLEEP_CMD);
      `CHK(sleep_mode, 1'b1)
      u_mst.open_frame();
      repeat (8) @(posedge mclk);
      `CHK(sleep_mode, 1'b0)
      u_mst.close_frame();
   endtask : t_modes

   task t_standby();
      repeat (STANDBY_ENTRY_CYC - 100) @(posedge mclk);
      `CHK(standby, 1'b0)
      repeat (200) @(posedge mclk);
      `CHK(standby, 1'b1)
      u_mst.open_frame();
      repeat (8) @(posedge mclk);
      `CHK(standby, 1'b0)
      u_mst.close_frame();
   endtask : t_standby

   task t_powerdown();
      power_good <= 1'b0;
      repeat (WRITE_FINISH_CYC * 2) @(posedge mclk);
      `CHK(hw_save_busy_pin, 1'b0)
      cmd(SLEEP_CMD);
      `CHK(sleep_mode, 1'b0)
   endtask : t_powerdown

   initial
   begin
      srst = 1'b1;
      power_good = 1'b1;
      wp_n = 1'b1;
      mem_wr_ready = 1'b1;
      mem_rd_data = 8'h00;
      oe_seen = 1'b0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      t_powerup();
      t_status();
      t_pin();
      t_awrite();
      t_fifo();
      t_read();
      t_restore();
      t_modes();
      t_standby();
      t_powerdown();
      summarize();
   end
endmodule : snv_core_test
